// >>> include/sound_control_pkg.sv
// Package for the decoded-audio sound control register bank.
// Assumes a 32-bit APB master; register indices are word indices (byte address = 4 * index).
package sound_control_pkg;

   localparam int ADDR_WIDTH = 10;
   localparam int DATA_WIDTH = 32;

   // Register indices
   localparam logic [7:0] LEFT_VOLUME_INDEX = 8'h9e;
   localparam logic [7:0] RIGHT_VOLUME_INDEX = 8'h9f;
   localparam logic [7:0] BASS_GAIN_INDEX = 8'hb4;
   localparam logic [7:0] MID_GAIN_INDEX = 8'hb5;
   localparam logic [7:0] TREBLE_GAIN_INDEX = 8'hb6;
   localparam logic [7:0] DECODER_CLOCK_DIVIDER_INDEX = 8'heb;
   localparam logic [7:0] AUDIO_CONTROL_ONE_INDEX = 8'hc0;

   // Field widths and positions
   localparam int VOLUME_WIDTH = 5;
   localparam int BASS_WIDTH = 5;
   localparam int MID_WIDTH = 6;
   localparam int TREBLE_WIDTH = 6;
   localparam int DIVIDER_WIDTH = 5;
   localparam int SOURCE_BIT = 0;
   localparam int FORMAT_LSB = 1;
   localparam int FORMAT_MSB = 2;
   localparam int SAMPLE_WIDTH = 16;
   localparam int MCU_SAMPLE_WIDTH = 8;

   // Values after reset
   localparam logic [7:0] SETTING_RESET = 8'h00;
   localparam logic [4:0] DIVIDER_RESET = 5'h00;
   localparam logic [4:0] SHIFT_RESET = 5'h00;

   // Justification shift of the output point per format
   localparam logic [4:0] SHIFT_LEFT_JUSTIFIED = 5'h00;
   localparam logic [4:0] SHIFT_RIGHT_JUSTIFIED = 5'h10;
   localparam logic [4:0] SHIFT_I2S = 5'h01;

   typedef enum logic [1:0] {
      FORMAT_LEFT = 2'b00,
      FORMAT_RIGHT = 2'b01,
      FORMAT_I2S = 2'b10,
      FORMAT_SPARE = 2'b11
   } audio_format_type;

   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_LEFT = 3'b001,
      SEL_RIGHT = 3'b010,
      SEL_BASS = 3'b011,
      SEL_MID = 3'b100,
      SEL_TREBLE = 3'b101,
      SEL_DIVIDER = 3'b110,
      SEL_CONTROL = 3'b111
   } reg_select_type;

   typedef struct packed {
      logic [VOLUME_WIDTH-1:0] leftVolume;
      logic [VOLUME_WIDTH-1:0] rightVolume;
      logic [BASS_WIDTH-1:0] bassGain;
      logic [MID_WIDTH-1:0] midGain;
      logic [TREBLE_WIDTH-1:0] trebleGain;
   } sound_settings_type;

   localparam sound_settings_type SETTINGS_RESET = '0;

endpackage

// >>> hw/sound_control_regs.sv
// Sound control register bank: volume, tone gains, decoder clock divider and
// output stream control, reached over APB.
// Assumes clk is the PLL clock and that sample inputs come from logic on clk.
// Overview of operation
// RULE1 - Unused upper bits of every register read back as zero.
// RULE2 - Software keeps unused upper bits at zero when writing.
// RULE3 - Left volume is five bits 4..0, driving left attenuation.
// RULE4 - Right volume is five bits 4..0, independent of left.
// RULE5 - Bass gain is five bits 4..0, setting low-band equalisation.
// RULE6 - Mid gain is six bits 5..0; bits 7 and 6 unused.
// RULE7 - Treble gain is six bits 5..0, setting high-band equalisation.
// RULE8 - Five-bit divider field generates the decoder clock.
// RULE9 - Reset clears every register of the bank to zero.
// RULE10 - Output offers left-justified, right-justified and I2S formats.
// RULE11 - Output stream comes from decoder samples or microcontroller samples.
// RULE12 - One source bit: zero picks decoder, one picks microcontroller.
// RULE13 - Decoder clock divides PLL clock; new divider applies from the write.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module sound_control_regs
   import sound_control_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sound_control_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic [sound_control_pkg::DATA_WIDTH-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [sound_control_pkg::DATA_WIDTH-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output sound_control_pkg::sound_settings_type soundSettings,
   output logic decoderClock,
   output sound_control_pkg::audio_format_type audioFormat,
   output logic [4:0] justifyShift,
   output logic streamSourceSelect,
   input wire logic [sound_control_pkg::SAMPLE_WIDTH-1:0] mp3Sample,
   input wire logic mp3Valid,
   output logic mp3Ready,
   input wire logic [sound_control_pkg::MCU_SAMPLE_WIDTH-1:0] mcuSample,
   input wire logic mcuValid,
   output logic mcuReady,
   output logic [sound_control_pkg::SAMPLE_WIDTH-1:0] streamSample,
   output logic streamValid
);
   import sound_control_pkg::*;

   logic readLoaded;
   logic writeEnable;
   logic dividerWrite;
   logic [DIVIDER_WIDTH-1:0] divValue;
   logic [DIVIDER_WIDTH-1:0] divCount;
   reg_select_type writeSel;

   function automatic reg_select_type decode(input logic [ADDR_WIDTH-1:0] addr);
      reg_select_type sel;
      sel = SEL_NONE;
      if (addr[1:0] == 2'b00)
      begin
         unique case (addr[ADDR_WIDTH-1:2])
            LEFT_VOLUME_INDEX: sel = SEL_LEFT;
            RIGHT_VOLUME_INDEX: sel = SEL_RIGHT;
            BASS_GAIN_INDEX: sel = SEL_BASS;
            MID_GAIN_INDEX: sel = SEL_MID;
            TREBLE_GAIN_INDEX: sel = SEL_TREBLE;
            DECODER_CLOCK_DIVIDER_INDEX: sel = SEL_DIVIDER;
            AUDIO_CONTROL_ONE_INDEX: sel = SEL_CONTROL;
            default: sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   // Fields are zero-extended, so the unused upper bits always read zero
   function automatic logic [DATA_WIDTH-1:0] readValue(input reg_select_type sel);
      logic [DATA_WIDTH-1:0] value;
      value = '0;
      unique case (sel)
         SEL_LEFT: value[VOLUME_WIDTH-1:0] = soundSettings.leftVolume; // RULE1
         SEL_RIGHT: value[VOLUME_WIDTH-1:0] = soundSettings.rightVolume; // RULE1
         SEL_BASS: value[BASS_WIDTH-1:0] = soundSettings.bassGain; // RULE1
         SEL_MID: value[MID_WIDTH-1:0] = soundSettings.midGain; // RULE1
         SEL_TREBLE: value[TREBLE_WIDTH-1:0] = soundSettings.trebleGain; // RULE1
         SEL_DIVIDER: value[DIVIDER_WIDTH-1:0] = divValue; // RULE1
         SEL_CONTROL:
         begin
            value[SOURCE_BIT] = streamSourceSelect;
            value[FORMAT_MSB:FORMAT_LSB] = audioFormat;
         end
         SEL_NONE: value = '0;
      endcase
      return value;
   endfunction

   // Read data is captured in the setup cycle so prdata comes from a flop;
   // this costs no wait state because the access phase answers at once.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata <= '0;
         readLoaded <= 1'b0;
      end
      else if (ce)
      begin
         if (psel && !penable)
         begin
            prdata <= readValue(decode(paddr));
            readLoaded <= 1'b1;
         end
         else if (psel && penable && readLoaded)
         begin
            readLoaded <= 1'b0;
         end
         else if (psel && penable)
         begin
            // Setup fell while ce was low: capture now at the cost of one wait state
            prdata <= readValue(decode(paddr));
            readLoaded <= 1'b1;
         end
      end
   end

   assign pready = psel && penable && readLoaded && ce;
   assign pslverr = pready && (decode(paddr) == SEL_NONE);
   assign writeSel = decode(paddr);
   // Only the low byte carries fields, so only its strobe matters
   assign writeEnable = pready && pwrite && pstrb[0];
   assign dividerWrite = writeEnable && (writeSel == SEL_DIVIDER);

   // Upper bits of pwdata are dropped, which software keeps at zero anyway
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         soundSettings <= SETTINGS_RESET; // RULE9
      end
      else if (writeEnable)
      begin
         unique case (writeSel)
            SEL_LEFT: soundSettings.leftVolume <= pwdata[VOLUME_WIDTH-1:0]; // RULE3
            SEL_RIGHT: soundSettings.rightVolume <= pwdata[VOLUME_WIDTH-1:0]; // RULE4
            SEL_BASS: soundSettings.bassGain <= pwdata[BASS_WIDTH-1:0]; // RULE5
            SEL_MID: soundSettings.midGain <= pwdata[MID_WIDTH-1:0]; // RULE6
            SEL_TREBLE: soundSettings.trebleGain <= pwdata[TREBLE_WIDTH-1:0]; // RULE7
            SEL_NONE, SEL_DIVIDER, SEL_CONTROL:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         streamSourceSelect <= 1'b0; // RULE9
         audioFormat <= FORMAT_LEFT;
         justifyShift <= SHIFT_RESET;
      end
      else if (writeEnable && (writeSel == SEL_CONTROL))
      begin
         streamSourceSelect <= pwdata[SOURCE_BIT]; // RULE12
         audioFormat <= audio_format_type'(pwdata[FORMAT_MSB:FORMAT_LSB]); // RULE10
         unique case (pwdata[FORMAT_MSB:FORMAT_LSB])
            FORMAT_RIGHT: justifyShift <= SHIFT_RIGHT_JUSTIFIED; // RULE10
            FORMAT_I2S: justifyShift <= SHIFT_I2S; // RULE10
            default: justifyShift <= SHIFT_LEFT_JUSTIFIED; // RULE10
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         divValue <= DIVIDER_RESET; // RULE9
      end
      else if (dividerWrite)
      begin
         divValue <= pwdata[DIVIDER_WIDTH-1:0]; // RULE8
      end
   end

   // Decoder clock period is 2 * (divValue + 1) PLL cycles. A write restarts
   // the count so the new ratio is used from the write onward.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         divCount <= DIVIDER_RESET;
         decoderClock <= 1'b0;
      end
      else if (ce)
      begin
         if (dividerWrite)
         begin
            divCount <= DIVIDER_RESET; // RULE13
         end
         else if (divCount >= divValue)
         begin
            divCount <= DIVIDER_RESET;
            decoderClock <= !decoderClock; // RULE8
         end
         else
         begin
            divCount <= divCount + 5'h01;
         end
      end
   end

   // Source mux; the unselected source is stalled rather than dropped
   assign mp3Ready = ce && !streamSourceSelect; // RULE11
   assign mcuReady = ce && streamSourceSelect; // RULE11

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         streamSample <= '0;
         streamValid <= 1'b0;
      end
      else if (ce)
      begin
         if (!streamSourceSelect)
         begin
            streamSample <= mp3Sample; // RULE12
            streamValid <= mp3Valid;
         end
         else
         begin
            // Byte samples widen to 16 bits with a zero low byte
            streamSample <= {mcuSample, 8'h00}; // RULE11
            streamValid <= mcuValid;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   property p_upper_zero;
      pready && !pwrite |-> prdata[DATA_WIDTH-1:MID_WIDTH] == '0
         && (decode(paddr) inside {SEL_MID, SEL_TREBLE} || prdata[5] == 1'b0);
   endproperty
   a_upper_zero: assert property (p_upper_zero) // RULE1
      else $error("Unused upper bits read back nonzero");

   property p_left_write;
      writeEnable && writeSel == SEL_LEFT
         |=> soundSettings.leftVolume == $past(pwdata[4:0]);
   endproperty
   a_left_write: assert property (p_left_write) // RULE3
      else $error("Left volume did not take the written value");

   property p_right_write;
      writeEnable && writeSel == SEL_RIGHT
         |=> soundSettings.rightVolume == $past(pwdata[4:0]);
   endproperty
   a_right_write: assert property (p_right_write) // RULE4
      else $error("Right volume did not take the written value");

   property p_right_independent;
      writeEnable && writeSel == SEL_LEFT |=> $stable(soundSettings.rightVolume)
         ##1 soundSettings.rightVolume == $past(soundSettings.rightVolume, 2)
         || $past(writeEnable);
   endproperty
   a_right_independent: assert property (p_right_independent) // RULE4
      else $error("Right volume changed on a left volume write");

   property p_bass_write;
      writeEnable && writeSel == SEL_BASS
         |=> soundSettings.bassGain == $past(pwdata[4:0]);
   endproperty
   a_bass_write: assert property (p_bass_write) // RULE5
      else $error("Bass gain did not take the written value");

   property p_mid_write;
      writeEnable && writeSel == SEL_MID
         |=> soundSettings.midGain == $past(pwdata[5:0]);
   endproperty
   a_mid_write: assert property (p_mid_write) // RULE6
      else $error("Mid gain did not take the written value");

   property p_treble_write;
      writeEnable && writeSel == SEL_TREBLE
         |=> soundSettings.trebleGain == $past(pwdata[5:0]);
   endproperty
   a_treble_write: assert property (p_treble_write) // RULE7
      else $error("Treble gain did not take the written value");

   property p_divider_toggle;
      $changed(decoderClock) |-> $past(divCount) == $past(divValue) && !$past(dividerWrite);
   endproperty
   a_divider_toggle: assert property (p_divider_toggle) // RULE8
      else $error("Decoder clock toggled off the divider count");

   property p_divider_restart;
      dividerWrite |=> divCount == 5'h00 && divValue == $past(pwdata[4:0]);
   endproperty
   a_divider_restart: assert property (p_divider_restart) // RULE13
      else $error("Divider write did not restart the count");

   property p_reset_clear;
      $rose(resetn) |-> soundSettings == SETTINGS_RESET && divValue == DIVIDER_RESET
         && !streamSourceSelect;
   endproperty
   a_reset_clear: assert property (p_reset_clear) // RULE9
      else $error("Register bank not cleared after reset");

   property p_i2s_shift;
      writeEnable && writeSel == SEL_CONTROL && pwdata[2:1] == 2'b10
         |=> audioFormat == FORMAT_I2S && justifyShift == 5'h01;
   endproperty
   a_i2s_shift: assert property (p_i2s_shift) // RULE10
      else $error("I2S format did not set its justification");

   property p_mp3_source;
      ce && !streamSourceSelect |=> streamSample == $past(mp3Sample)
         && streamValid == $past(mp3Valid);
   endproperty
   a_mp3_source: assert property (p_mp3_source) // RULE12
      else $error("Decoder source not passed to stream");

   property p_mcu_source;
      ce && streamSourceSelect |-> mcuReady && !mp3Ready
         ##1 streamSample == {$past(mcuSample), 8'h00};
   endproperty
   a_mcu_source: assert property (p_mcu_source) // RULE11
      else $error("Microcontroller source not passed to stream");

   property p_ce_freeze;
      !ce |=> $stable(soundSettings) && $stable(decoderClock) && $stable(streamSample);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze)
      else $error("State changed while clock enable was low");

   c_left_write: cover property (writeEnable && writeSel == SEL_LEFT);
   c_mid_read: cover property (pready && !pwrite && decode(paddr) == SEL_MID);
   c_mcu_stream: cover property (streamSourceSelect && streamValid);
   c_decoder_toggle: cover property (divValue != 5'h00 && $changed(decoderClock));

endmodule

// >>> tb/tb.sv
// Self-checking bench for the sound control register bank.
// Assumes the bank answers APB within a bounded wait; ce is high except where a scenario drops it.
`timescale 1ns/1ps
module tb;
   import sound_control_pkg::*;
   logic clk;
   logic resetn;
   logic ce;
   logic psel;
   logic penable;
   logic pwrite;
   logic [9:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   sound_settings_type soundSettings;
   logic decoderClock;
   audio_format_type audioFormat;
   logic [4:0] justifyShift;
   logic streamSourceSelect;
   logic [15:0] mp3Sample;
   logic mp3Valid;
   logic mp3Ready;
   logic [7:0] mcuSample;
   logic mcuValid;
   logic mcuReady;
   logic [15:0] streamSample;
   logic streamValid;
   int error_cnt;
   int comparisons;
   logic [31:0] rd;
   logic err;

   sound_control_regs dut (.clk(clk), .resetn(resetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .soundSettings(soundSettings),
      .decoderClock(decoderClock), .audioFormat(audioFormat), .justifyShift(justifyShift),
      .streamSourceSelect(streamSourceSelect), .mp3Sample(mp3Sample), .mp3Valid(mp3Valid),
      .mp3Ready(mp3Ready), .mcuSample(mcuSample), .mcuValid(mcuValid), .mcuReady(mcuReady),
      .streamSample(streamSample), .streamValid(streamValid));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task end_sim;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // The request stands until pready is seen high at a rising edge, for at most 20 access cycles before the run ends
   task apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         error_cnt++;
         $display("unexpected at %0t: no ready", $time);
         end_sim();
      end
      else
      begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   function automatic logic [9:0] addr(input logic [7:0] idx);
      return {idx, 2'b00};
   endfunction

   task test_reset;
      logic [7:0] idx[7];
      idx = '{8'h9e, 8'h9f, 8'hb4, 8'hb5, 8'hb6, 8'heb, 8'hc0};
      foreach (idx[i])
      begin
         apb(1'b0, addr(idx[i]), 32'h0000_0000);
         check(rd, 32'h0000_0000, "reset value");
      end
      check(32'(soundSettings), 32'h0000_0000, "settings after reset");
   endtask

   task test_fields;
      logic [7:0] idx[5];
      logic [31:0] val[5];
      idx = '{8'h9e, 8'h9f, 8'hb4, 8'hb5, 8'hb6};
      val = '{32'h0000_0015, 32'h0000_000a, 32'h0000_001f, 32'h0000_003f, 32'h0000_002a};
      foreach (idx[i])
         apb(1'b1, addr(idx[i]), val[i]);
      foreach (idx[i])
      begin
         apb(1'b0, addr(idx[i]), 32'h0000_0000);
         check(rd, val[i], "field readback");
      end
      check(32'(soundSettings), {5'h00, 5'h15, 5'h0a, 5'h1f, 6'h3f, 6'h2a}, "settings");
   endtask

   task test_unmapped;
      apb(1'b1, addr(8'h10), 32'h0000_0011);
      check(32'(err), 32'h0000_0001, "unmapped write error");
      apb(1'b0, addr(8'h10), 32'h0000_0000);
      check(rd, 32'h0000_0000, "unmapped read");
      check(32'(err), 32'h0000_0001, "unmapped read error");
      apb(1'b0, 10'h279, 32'h0000_0000);
      check(32'(err), 32'h0000_0001, "misaligned error");
   endtask

   task test_divider;
      logic [4:0] div[3];
      int n;
      int start;
      logic prev;
      div = '{5'h00, 5'h02, 5'h1f};
      foreach (div[i])
      begin
         apb(1'b1, addr(8'heb), {27'h0, div[i]});
         apb(1'b0, addr(8'heb), 32'h0000_0000);
         check(rd, {27'h0, div[i]}, "divider readback");
         start = -1;
         prev = decoderClock;
         for (n = 0; n < 300; n++)
         begin
            @(negedge clk);
            if (!prev && decoderClock)
            begin
               if (start >= 0)
                  break;
               start = n;
            end
            prev = decoderClock;
         end
         check(n - start, 2 * (div[i] + 1), "decoder clock period");
      end
   endtask

   task test_formats;
      logic [4:0] shift[4];
      shift = '{5'h00, 5'h10, 5'h01, 5'h00};
      for (int f = 0; f < 4; f++)
      begin
         apb(1'b1, addr(8'hc0), 32'(f << 1));
         @(negedge clk);
         check(32'(audioFormat), 32'(f), "format");
         check(32'(justifyShift), 32'(shift[f]), "justify shift");
      end
   endtask

   task test_stream;
      @(posedge clk);
      mp3Sample <= 16'ha5c3;
      mp3Valid <= 1'b0;
      mcuSample <= 8'h7e;
      mcuValid <= 1'b1;
      apb(1'b1, addr(8'hc0), 32'h0000_0000);
      repeat (2) @(negedge clk);
      check({mp3Ready, mcuReady, streamSourceSelect}, 32'h0000_0004, "decoder ready");
      check(32'(streamSample), 32'h0000_a5c3, "decoder stream");
      check(32'(streamValid), 32'h0000_0000, "decoder valid");
      apb(1'b1, addr(8'hc0), 32'h0000_0001);
      repeat (2) @(negedge clk);
      check({mp3Ready, mcuReady, streamSourceSelect}, 32'h0000_0003, "core ready");
      check(32'(streamSample), 32'h0000_7e00, "core stream");
      check(32'(streamValid), 32'h0000_0001, "core valid");
      @(posedge clk);
      ce <= 1'b0;
      mcuSample <= 8'h11;
      repeat (2) @(negedge clk);
      check({mp3Ready, mcuReady, streamSourceSelect}, 32'h0000_0001, "frozen ready");
      check(32'(streamSample), 32'h0000_7e00, "frozen stream");
      @(posedge clk);
      ce <= 1'b1;
   endtask

   // A second reset after the bank has been written must clear it again
   task test_rerun_reset;
      @(posedge clk);
      resetn <= 1'b0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      test_reset();
   endtask

   initial
   begin
      error_cnt = 0;
      comparisons = 0;
      resetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
      mp3Sample = 16'h0000;
      mp3Valid = 1'b0;
      mcuSample = 8'h00;
      mcuValid = 1'b0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      test_reset();
      test_fields();
      test_unmapped();
      test_divider();
      test_formats();
      test_stream();
      test_rerun_reset();
      end_sim();
   end
endmodule
